// ===== common/cnt_freq_pkg.sv
// Constants, register map and state carriers for the counter input block.
// Assumes a single 40 MHz clock that also serves as the measurement time base.
package cnt_freq_pkg;

	// ==================================================================
	// Timing
	localparam int unsigned CLK_PERIOD_PS = 25000;
	localparam int unsigned NUM_IN = 2;
	localparam int unsigned GATE_SEL_W = 3;
	localparam int unsigned GATE_CNT_W = 8;
	localparam int unsigned GATE_NS [8] = '{0, 100, 200, 500, 1000, 2000, 4000, 5000};

	// A least time rounds up to whole clock cycles.
	function automatic logic [GATE_CNT_W-1:0] gate_cycles(input logic [GATE_SEL_W-1:0] sel);
		int unsigned ps;
		ps = GATE_NS[sel] * 1000;
		return GATE_CNT_W'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	endfunction : gate_cycles

	// ==================================================================
	// Widths
	localparam int unsigned CNT_W = 32;
	localparam int unsigned SUB_W = 24;
	localparam int unsigned FRAC_W = 16;
	localparam int unsigned STEP_W = 5;
	localparam int unsigned SEQ_W = 16;
	localparam int unsigned REG_ADDR_W = 8;
	localparam logic [SUB_W-1:0] SUB_MAX = 24'hffffff;

	// ==================================================================
	// Register map (byte addresses)
	localparam logic [REG_ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [REG_ADDR_W-1:0] ADDR_FILTER = 8'h04;
	localparam logic [REG_ADDR_W-1:0] ADDR_COUNT = 8'h08;
	localparam logic [REG_ADDR_W-1:0] ADDR_SMP_COUNT = 8'h0c;
	localparam logic [REG_ADDR_W-1:0] ADDR_SMP_SUB = 8'h10;
	localparam logic [REG_ADDR_W-1:0] ADDR_SMP_INTERP = 8'h14;
	localparam logic [REG_ADDR_W-1:0] ADDR_SMP_PERIOD = 8'h18;
	localparam logic [REG_ADDR_W-1:0] ADDR_STATUS = 8'h1c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {MODE_EVENT, MODE_UPDOWN} mode_t;
	typedef enum logic {DIV_IDLE, DIV_RUN} div_state_t;

	// Control word, bit 0 is run.
	typedef struct packed {
		logic zero_out;
		mode_t mode;
		logic count_down;
		logic keep_on_start;
		logic run;
	} ctrl_t;
	localparam int unsigned CTRL_W = $bits(ctrl_t);
	localparam int unsigned FILT_W = NUM_IN * GATE_SEL_W;

	typedef struct packed {
		logic [NUM_IN-1:0] in_meta;
		logic [NUM_IN-1:0] in_sync;
		logic [NUM_IN-1:0] filt;
		logic [NUM_IN-1:0] filt_d;
		logic [NUM_IN-1:0][GATE_CNT_W-1:0] stab_cnt;
		logic [1:0] smp_sync;
		logic smp_d;
		logic run_d;
		logic [CNT_W-1:0] count;
		logic [SUB_W-1:0] sub_cnt;
		logic [SUB_W-1:0] sub_hold;
		logic [SUB_W-1:0] since_evt;
		logic [SUB_W-1:0] period_cnt;
		logic [SUB_W-1:0] period_last;
		logic period_valid;
		logic period_new;
		logic [CNT_W-1:0] smp_count;
		logic [SUB_W-1:0] smp_sub;
		logic [SUB_W-1:0] smp_period;
		logic [SEQ_W-1:0] smp_seq;
		div_state_t div_state;
		logic [STEP_W-1:0] div_step;
		logic [SUB_W:0] div_rem;
		logic [SUB_W-1:0] div_per;
		logic [FRAC_W-1:0] div_q;
		logic [FRAC_W-1:0] smp_frac;
		ctrl_t ctrl;
		logic [NUM_IN-1:0][GATE_SEL_W-1:0] gate;
		logic aw_got;
		logic [REG_ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

endpackage : cnt_freq_pkg

// ===== hdl/cnt_freq_top.sv
// Counter input block: glitch filters, up/down counting, sub counter
// timing, period output and interpolated count, behind an AXI4-Lite slave.
// Assumes asynchronous pins on count_in and sample_clk_in and one clock.
//
// Overview of operation
// - Up/down mode: each rising edge on input A adds one.
// - Up/down mode: each rising edge on input B subtracts one.
// - Each sample edge captures the count without disturbing counting.
// - Main event counter runs beside a sub counter timing input events.
// - Sub counter times events from the sample edge, one time base tick each.
// - Each rising edge on input A latches the sub counter into a holder.
// - Each sample edge reads main count and held sub value together.
// - Count is interpolated to the sample instant as integer plus fraction.
// - Each input has its own filter; setting off passes the input straight.
// - Filter samples each tick; new level passes after holding the gate time.
// - Accepted transitions appear delayed by the selected gate time.
// - Eight gate settings: off, 100, 200, 500 ns, 1, 2, 4, 5 us.
// - Time base period sets filter and sub counter resolution.
// - Pulses at least the gate time pass; two ticks shorter are blocked.
// - Pulses between those widths may pass depending on phase.
// - Acquisition start clears the count unless the keep option is set.
// - With keep set, counting goes on while acquisition is stopped.
// - Default direction is up, one per rising edge.
// - A direction bit makes the single-input counter count down.
// - Repeat mode: period output holds the last value until a newer one.
// - Zero mode: period output is zero when no new period completed.
`timescale 1ns/1ps
`default_nettype none

module cnt_freq_top
	import cnt_freq_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [NUM_IN-1:0] count_in,
	input wire logic sample_clk_in,
	input wire logic [REG_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [REG_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	state_t st_reg;
	state_t st_next;

	logic [NUM_IN-1:0] rise;
	logic up_ev;
	logic dn_ev;
	logic smp_edge;
	logic start_clear;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic [REG_ADDR_W-1:0] w_addr;
	logic [REG_ADDR_W-1:0] r_addr;
	logic [31:0] rd_word;
	logic rd_hit;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	// ==================================================================
	// Event decode
	assign rise = st_reg.filt & ~st_reg.filt_d;
	// Direction bit only applies outside up/down mode, where input B is the down source.
	assign up_ev = (st_reg.ctrl.mode == MODE_UPDOWN) ? rise[0] : (rise[0] & ~st_reg.ctrl.count_down);
	assign dn_ev = (st_reg.ctrl.mode == MODE_UPDOWN) ? rise[1] : (rise[0] & st_reg.ctrl.count_down);
	assign smp_edge = st_reg.smp_sync[1] & ~st_reg.smp_d;
	assign start_clear = st_reg.ctrl.run & ~st_reg.run_d & ~st_reg.ctrl.keep_on_start;

	// ==================================================================
	// Bus handshakes
	assign s_axi_awready = ~st_reg.aw_got & ~st_reg.bvalid;
	assign s_axi_wready = ~st_reg.w_got & ~st_reg.bvalid;
	assign s_axi_arready = ~st_reg.rvalid;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign w_addr = {st_reg.aw_addr[REG_ADDR_W-1:2], 2'h0};
	assign r_addr = {s_axi_araddr[REG_ADDR_W-1:2], 2'h0};

	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		unique case (r_addr)
			ADDR_CTRL: rd_word[CTRL_W-1:0] = st_reg.ctrl;
			ADDR_FILTER: rd_word[FILT_W-1:0] = st_reg.gate;
			ADDR_COUNT: rd_word = st_reg.count;
			ADDR_SMP_COUNT: rd_word = st_reg.smp_count;
			ADDR_SMP_SUB: rd_word[SUB_W-1:0] = st_reg.smp_sub;
			ADDR_SMP_INTERP: rd_word = {st_reg.smp_count[CNT_W-FRAC_W-1:0], st_reg.smp_frac};
			ADDR_SMP_PERIOD: rd_word[SUB_W-1:0] = st_reg.smp_period;
			ADDR_STATUS: rd_word = {st_reg.smp_seq, 15'h0000, st_reg.div_state == DIV_RUN};
			default: rd_hit = 1'b0;
		endcase
	end

	// ==================================================================
	// Next state
	always_comb begin
		st_next = st_reg;

		// Two flip-flops before any logic looks at a pin.
		st_next.in_meta = count_in;
		st_next.in_sync = st_reg.in_meta;
		st_next.smp_sync = {st_reg.smp_sync[0], sample_clk_in};
		st_next.smp_d = st_reg.smp_sync[1];
		st_next.run_d = st_reg.ctrl.run;

		// A level must differ for gate_cycles consecutive ticks before it is taken,
		// so a pulse shorter by two ticks can never win, whatever its phase.
		for (int i = 0; i < NUM_IN; i++) begin
			if (st_reg.gate[i] == '0) begin
				st_next.filt[i] = st_reg.in_sync[i];
				st_next.stab_cnt[i] = '0;
			end else if (st_reg.in_sync[i] == st_reg.filt[i]) begin
				st_next.stab_cnt[i] = '0;
			end else if (st_reg.stab_cnt[i] == gate_cycles(st_reg.gate[i]) - 1'b1) begin
				st_next.filt[i] = st_reg.in_sync[i];
				st_next.stab_cnt[i] = '0;
			end else begin
				st_next.stab_cnt[i] = st_reg.stab_cnt[i] + 1'b1;
			end
		end
		st_next.filt_d = st_reg.filt;

		// Main counter keeps running whatever the run bit says.
		if (start_clear) begin
			st_next.count = '0;
		end
		if (up_ev && !dn_ev) begin
			st_next.count = (start_clear ? '0 : st_reg.count) + 1'b1;
		end else if (dn_ev && !up_ev) begin
			st_next.count = (start_clear ? '0 : st_reg.count) - 1'b1;
		end

		// The time base is aclk itself, so one sub counter tick is one clock period.
		// Sub counter restarts at every sample edge and saturates.
		if (smp_edge) begin
			st_next.sub_cnt = '0;
		end else if (st_reg.sub_cnt != SUB_MAX) begin
			st_next.sub_cnt = st_reg.sub_cnt + 1'b1;
		end
		if (st_reg.since_evt != SUB_MAX) begin
			st_next.since_evt = st_reg.since_evt + 1'b1;
		end
		if (st_reg.period_cnt != SUB_MAX) begin
			st_next.period_cnt = st_reg.period_cnt + 1'b1;
		end
		if (rise[0]) begin
			st_next.sub_hold = st_reg.sub_cnt;
			st_next.since_evt = '0;
			st_next.period_cnt = SUB_W'(1);
			st_next.period_last = st_reg.period_cnt;
			st_next.period_valid = 1'b1;
		end
		if (rise[0] && st_reg.period_valid) begin
			st_next.period_new = 1'b1;
		end else if (smp_edge) begin
			st_next.period_new = 1'b0;
		end

		// Coherent capture of everything in the sample edge cycle.
		if (smp_edge) begin
			st_next.smp_count = st_reg.count;
			st_next.smp_sub = st_reg.sub_hold;
			st_next.smp_seq = st_reg.smp_seq + 1'b1;
			if (st_reg.period_new) begin
				st_next.smp_period = st_reg.period_last;
			end else if (st_reg.ctrl.zero_out) begin
				st_next.smp_period = '0;
			end else begin
				st_next.smp_period = st_reg.smp_period;
			end
		end

		// Fraction of the running event period elapsed at the sample instant,
		// by restoring division; a new sample while busy keeps the older fraction.
		unique case (st_reg.div_state)
			DIV_IDLE: begin
				if (smp_edge) begin
					st_next.div_q = '0;
					st_next.div_step = '0;
					if (st_reg.period_valid && st_reg.period_last != '0) begin
						st_next.div_state = DIV_RUN;
						st_next.div_per = st_reg.period_last;
						st_next.div_rem = (st_reg.since_evt >= st_reg.period_last) ?
							{1'b0, st_reg.period_last - 1'b1} : {1'b0, st_reg.since_evt};
					end else begin
						st_next.smp_frac = '0;
					end
				end
			end
			DIV_RUN: begin
				st_next.div_rem = {st_reg.div_rem[SUB_W-1:0], 1'b0};
				st_next.div_q = {st_reg.div_q[FRAC_W-2:0], 1'b0};
				if ({st_reg.div_rem[SUB_W-1:0], 1'b0} >= {1'b0, st_reg.div_per}) begin
					st_next.div_rem = {st_reg.div_rem[SUB_W-1:0], 1'b0} - {1'b0, st_reg.div_per};
					st_next.div_q[0] = 1'b1;
				end
				st_next.div_step = st_reg.div_step + 1'b1;
				if (st_reg.div_step == STEP_W'(FRAC_W - 1)) begin
					st_next.div_state = DIV_IDLE;
					st_next.smp_frac = st_next.div_q;
				end
			end
		endcase

		// Write channel: address and data in either order, response after both.
		if (aw_take) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (w_take) begin
			st_next.w_got = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (st_reg.aw_got && st_reg.w_got) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = RESP_OKAY;
			if (w_addr == ADDR_CTRL) begin
				st_next.ctrl = ctrl_t'(merge_bytes(32'(st_reg.ctrl), st_reg.w_data, st_reg.w_strb));
			end else if (w_addr == ADDR_FILTER) begin
				st_next.gate = FILT_W'(merge_bytes(32'(st_reg.gate), st_reg.w_data, st_reg.w_strb));
			end else if (w_addr > ADDR_STATUS) begin
				st_next.bresp = RESP_SLVERR;
			end
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// Read channel: data one cycle after the address is taken.
		if (ar_take) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd_word;
			st_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==================================================================
	// Checks
	a_filter_off: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(st_reg.gate[0]) == '0 && st_reg.gate[0] == '0) |=> st_reg.filt[0] == $past(st_reg.in_sync[0]))
		else $error("unfiltered input did not pass straight");

	a_filter_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.gate[0] == 3'h1 && $past(st_reg.gate[0], 5) == 3'h1 && $changed(st_reg.filt[0]))
		|-> ($past(st_reg.in_sync[0], 1) == st_reg.filt[0] && $past(st_reg.in_sync[0], 4) == st_reg.filt[0]))
		else $error("filter passed a level held shorter than the gate time");

	a_count_up: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.ctrl.mode == MODE_UPDOWN && rise[0] && !rise[1] && !start_clear)
		|=> st_reg.count == $past(st_reg.count) + 1'b1)
		else $error("up edge did not add one");

	a_count_down: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.ctrl.mode == MODE_UPDOWN && rise[1] && !rise[0] && !start_clear)
		|=> st_reg.count == $past(st_reg.count) - 1'b1)
		else $error("down edge did not subtract one");

	a_event_up: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.ctrl.mode == MODE_EVENT && !st_reg.ctrl.count_down && rise[0] && !start_clear)
		|=> st_reg.count == $past(st_reg.count) + 1'b1)
		else $error("event mode did not count up");

	a_event_down: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.ctrl.mode == MODE_EVENT && st_reg.ctrl.count_down && rise[0] && !start_clear)
		|=> st_reg.count == $past(st_reg.count) - 1'b1)
		else $error("event mode did not count down");

	a_period_take: assert property (@(posedge aclk) disable iff (!aresetn)
		(smp_edge && st_reg.period_new) |=> st_reg.smp_period == $past(st_reg.period_last))
		else $error("new period not taken at the sample edge");

	a_sub_latch: assert property (@(posedge aclk) disable iff (!aresetn)
		rise[0] |=> st_reg.sub_hold == $past(st_reg.sub_cnt))
		else $error("sub counter not latched on source edge");

	a_sample_capture: assert property (@(posedge aclk) disable iff (!aresetn)
		smp_edge |=> (st_reg.smp_count == $past(st_reg.count) && st_reg.sub_cnt == '0))
		else $error("sample edge did not capture the count");

	a_start_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(start_clear && !up_ev && !dn_ev) |=> st_reg.count == '0)
		else $error("count not cleared at acquisition start");

	a_zero_out: assert property (@(posedge aclk) disable iff (!aresetn)
		(smp_edge && st_reg.ctrl.zero_out && !st_reg.period_new) |=> st_reg.smp_period == '0)
		else $error("zero mode did not output zero");

	a_repeat_last: assert property (@(posedge aclk) disable iff (!aresetn)
		(smp_edge && !st_reg.ctrl.zero_out && !st_reg.period_new) |=> $stable(st_reg.smp_period))
		else $error("repeat mode changed the period without a new value");

	a_div_bound: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(st_reg.div_state == DIV_RUN) |-> ##[15:16] st_reg.div_state == DIV_IDLE)
		else $error("interpolation did not finish in time");

endmodule : cnt_freq_top

`default_nettype wire

// ===== dv/pulse_src.sv
// Stand-in for the external pulse sources and the acquisition sample clock.
// Assumes one caller at a time; every pin change lands by non-blocking
// assignment just after a rising aclk edge, so widths are whole ticks.
`timescale 1ns/1ps
`default_nettype none

module pulse_src (
	input wire logic aclk,
	output logic [1:0] count_in,
	output logic sample_clk_in
);
	initial begin
		count_in = 2'h0;
		sample_clk_in = 1'b0;
	end

	// ==================================================================
	// Pulses
	// Rising edges of two back-to-back calls are hi + lo + 1 ticks apart.
	task automatic pulse(input int idx, input int hi, input int lo);
		@(posedge aclk);
		count_in[idx] <= 1'b1;
		repeat (hi) @(posedge aclk);
		count_in[idx] <= 1'b0;
		repeat (lo) @(posedge aclk);
	endtask : pulse

	// The trailing idle ticks cover the capture delay of the sample edge.
	task automatic sample();
		@(posedge aclk);
		sample_clk_in <= 1'b1;
		repeat (2) @(posedge aclk);
		sample_clk_in <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask : sample
endmodule : pulse_src
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the counter input block over AXI4-Lite.
// Assumes the pulse_src model on the pins and one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb;
	import cnt_freq_pkg::*;
	logic aclk;
	logic aresetn;
	logic [1:0] count_in;
	logic sample_clk_in;
	logic [7:0] awaddr;
	logic awvalid;
	logic awready;
	logic [31:0] wdata;
	logic wvalid;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready;
	logic [7:0] araddr;
	logic arvalid;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready;
	int failures;
	int total_checks;
	logic [31:0] exp_cnt;
	logic [31:0] d;
	logic [31:0] s0;
	logic [1:0] r;
	logic [15:0] seq;
	logic [2:0] sel;
	int n;
	int t;
	int p;
	int dd0;
	int dd1;
	int b;

	cnt_freq_top i_dut (.aclk(aclk), .aresetn(aresetn), .count_in(count_in), .sample_clk_in(sample_clk_in),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	pulse_src i_src (.aclk(aclk), .count_in(count_in), .sample_clk_in(sample_clk_in));

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// ==================================================================
	// Reporting
	task automatic give_verdict();
		if (failures == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask : chk

	// With no event since the last period, the fraction stops just short of one.
	function automatic logic [31:0] exp_frac(input int per);
		return 32'(((per - 1) * (1 << FRAC_W)) / per);
	endfunction : exp_frac

	// ==================================================================
	// Bus master
	// Ready is looked at on the falling edge, where it already shows what
	// the next rising edge will sample, so no race with the slave arises.
	task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
		logic aw;
		logic w;
		logic bh;
		int k;
		bh = 1'b0;
		k = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bh) begin
			@(negedge aclk);
			aw = awvalid && awready;
			w = wvalid && wready;
			bh = bvalid && bready;
			resp = bresp;
			@(posedge aclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (bh) bready <= 1'b0;
			k++;
			if (k > 1000) begin
				failures++;
				give_verdict();
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
		logic ar;
		logic rh;
		int k;
		rh = 1'b0;
		k = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rh) begin
			@(negedge aclk);
			ar = arvalid && arready;
			rh = rvalid && rready;
			dat = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ar) arvalid <= 1'b0;
			if (rh) rready <= 1'b0;
			k++;
			if (k > 1000) begin
				failures++;
				give_verdict();
			end
		end
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] dat;
		logic [1:0] resp;
		rd(a, dat, resp);
		chk(32'(resp), 32'(RESP_OKAY));
		chk(dat, exp);
	endtask : rdc

	// ==================================================================
	// Main sequence
	initial begin
		aresetn = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		failures = 0;
		total_checks = 0;
		exp_cnt = 32'h0;
		void'($urandom(97195));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rdc(ADDR_CTRL, 32'h0);
		rdc(ADDR_FILTER, 32'h0);
		rd(8'h20, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(ADDR_COUNT, 32'h55, r);
		rdc(ADDR_COUNT, 32'h0);
		wr(8'h24, 32'h1, r);
		chk(32'(r), 32'(RESP_SLVERR));
		// Single input, up then down; the keep bit stops later run edges clearing.
		wr(ADDR_CTRL, 32'h02, r);
		n = $urandom_range(8, 1);
		repeat (n) i_src.pulse(0, 1, 6);
		exp_cnt += n;
		rdc(ADDR_COUNT, exp_cnt);
		wr(ADDR_CTRL, 32'h06, r);
		n = $urandom_range(8, 1);
		repeat (n) i_src.pulse(0, 1, 6);
		exp_cnt -= n;
		rdc(ADDR_COUNT, exp_cnt);
		// Up/down mode with one-tick pulses back to back on random inputs.
		wr(ADDR_CTRL, 32'h0a, r);
		for (int k = 0; k < 12; k++) begin
			b = $urandom_range(1, 0);
			i_src.pulse(b, 1, 1);
			exp_cnt = b ? exp_cnt - 1 : exp_cnt + 1;
		end
		repeat (6) @(posedge aclk);
		rdc(ADDR_COUNT, exp_cnt);
		rd(ADDR_STATUS, d, r);
		seq = d[31:16];
		i_src.sample();
		rdc(ADDR_SMP_COUNT, exp_cnt);
		repeat (20) @(posedge aclk);
		rd(ADDR_SMP_INTERP, d, r);
		chk(32'(d[31:16]), 32'(exp_cnt[15:0]));
		rd(ADDR_STATUS, d, r);
		chk({d[31:16], 15'h0, d[0]}, {seq + 16'h1, 16'h0});
		// Acquisition start with and without the keep option.
		wr(ADDR_CTRL, 32'h03, r);
		rdc(ADDR_COUNT, exp_cnt);
		wr(ADDR_CTRL, 32'h02, r);
		repeat (3) i_src.pulse(0, 1, 6);
		exp_cnt += 3;
		rdc(ADDR_COUNT, exp_cnt);
		wr(ADDR_CTRL, 32'h01, r);
		exp_cnt = 32'h0;
		rdc(ADDR_COUNT, exp_cnt);
		wr(ADDR_CTRL, 32'h02, r);
		// Every gate setting: off passes a one-tick pulse; otherwise a pulse of the gate width passes late, two ticks less is blocked.
		for (int i = 0; i < 8; i++) begin
			sel = 3'(i);
			t = GATE_NS[i] / 25;
			wr(ADDR_FILTER, {26'h0, sel, sel}, r);
			if (i == 0) begin
				i_src.pulse(0, 1, 6);
				exp_cnt++;
				rdc(ADDR_COUNT, exp_cnt);
			end else begin
				i_src.pulse(0, t, 0);
				rdc(ADDR_COUNT, exp_cnt);
				repeat (t + 10) @(posedge aclk);
				exp_cnt++;
				rdc(ADDR_COUNT, exp_cnt);
				i_src.pulse(0, t - 2, t + 10);
				rdc(ADDR_COUNT, exp_cnt);
			end
		end
		// Period output in repeat mode, then in zero mode.
		wr(ADDR_FILTER, 32'h0, r);
		p = $urandom_range(40, 10);
		repeat (4) i_src.pulse(0, p / 2, p - p / 2 - 1);
		i_src.sample();
		rdc(ADDR_SMP_PERIOD, 32'(p));
		repeat (50) @(posedge aclk);
		i_src.sample();
		rdc(ADDR_SMP_PERIOD, 32'(p));
		repeat (20) @(posedge aclk);
		rd(ADDR_SMP_INTERP, d, r);
		chk(32'(d[15:0]), exp_frac(p));
		wr(ADDR_CTRL, 32'h12, r);
		repeat (3) i_src.pulse(0, p / 2, p - p / 2 - 1);
		i_src.sample();
		rdc(ADDR_SMP_PERIOD, 32'(p));
		i_src.sample();
		rdc(ADDR_SMP_PERIOD, 32'h0);
		// Event timing from the sample edge, compared between two random offsets.
		dd0 = $urandom_range(50, 5);
		dd1 = dd0 + $urandom_range(20, 1);
		i_src.sample();
		repeat (dd0) @(posedge aclk);
		i_src.pulse(0, 3, 10);
		i_src.sample();
		rd(ADDR_SMP_SUB, s0, r);
		i_src.sample();
		repeat (dd1) @(posedge aclk);
		i_src.pulse(0, 3, 10);
		i_src.sample();
		rd(ADDR_SMP_SUB, d, r);
		chk(d - s0, 32'(dd1 - dd0));
		give_verdict();
	end
endmodule : tb
`default_nettype wire
